// file: occ_control.sv
`timescale 1ns/1ns
`include "occ_map.svh"

module occ_control #(
	parameter int AW = 14
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic internal_osc_on,
	output logic crystal_osc_on,
	output logic watchdog_osc_on,
	output logic primary_fail_detect_on,
	output logic watchdog_fail_detect_on,
	output logic [2:0] system_clock_source_select,
	output logic crystal_pin_a_override,
	output logic crystal_pin_b_override,
	output logic device_halted
);

	////////////////////////////////////////////////////////////////////////////////
	// address decode

	function automatic logic [AW-1:0] byte_addr(input logic [11:0] idx);
		byte_addr = AW'({idx, 2'b00});
	endfunction : byte_addr

	occ_pkg::occ_state_type state;
	occ_pkg::occ_state_type next_state;

	logic access;
	logic hit_ctl;
	logic hit_stat;
	logic wr_ctl;
	logic [7:0] wbyte;
	logic all_off;

	assign hit_ctl = (paddr == byte_addr(`OCC_CTL_IDX));
	assign hit_stat = (paddr == byte_addr(`OCC_STAT_IDX));
	assign access = psel && penable && clk_en;
	assign wr_ctl = access && pwrite && hit_ctl && !state.halted;
	assign wbyte = pwdata[7:0];

	// nothing left that could run or recover the clock
	assign all_off = !state.ctl[`OCC_BIT_INT] && !state.ctl[`OCC_BIT_XTL]
		&& !state.ctl[`OCC_BIT_WDT] && !state.ctl[`OCC_BIT_PFD]
		&& !state.ctl[`OCC_BIT_WFD];

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_state = state;
		if (all_off) begin
			next_state.halted = 1'b1;
		end
		if (wr_ctl) begin
			case (state.lock)
				occ_pkg::occ_locked: begin
					if (wbyte == `OCC_KEY_FIRST) begin
						next_state.lock = occ_pkg::occ_armed;
					end else begin
						next_state.lock = occ_pkg::occ_locked;
					end
				end
				occ_pkg::occ_armed: begin
					if (wbyte == `OCC_KEY_SECOND) begin
						next_state.lock = occ_pkg::occ_open;
					end else begin
						next_state.lock = occ_pkg::occ_locked;
					end
				end
				occ_pkg::occ_open: begin
					next_state.ctl = wbyte;
					next_state.lock = occ_pkg::occ_locked;
				end
				default: begin
					next_state.lock = occ_pkg::occ_locked;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state.ctl <= `OCC_CTL_RESET;
			state.lock <= occ_pkg::occ_locked;
			state.halted <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// oscillator controls

	assign internal_osc_on = state.ctl[`OCC_BIT_INT] && !state.halted;
	assign crystal_osc_on = state.ctl[`OCC_BIT_XTL] && !state.halted;
	assign watchdog_osc_on = state.ctl[`OCC_BIT_WDT] && !state.halted;
	assign primary_fail_detect_on = state.ctl[`OCC_BIT_PFD] && !state.halted;
	assign watchdog_fail_detect_on = state.ctl[`OCC_BIT_WFD] && !state.halted;
	assign system_clock_source_select = state.ctl[`OCC_SEL_HI:`OCC_SEL_LO];
	// crystal takes both pins away from the port logic
	assign crystal_pin_a_override = crystal_osc_on;
	assign crystal_pin_b_override = crystal_osc_on;
	assign device_halted = state.halted;

	////////////////////////////////////////////////////////////////////////////////
	// bus answer

	assign pready = clk_en;
	assign pslverr = access && !hit_ctl && !hit_stat;

	always_comb begin
		prdata = 32'h0000_0000;
		if (hit_ctl) begin
			prdata[7:0] = state.ctl;
		end else if (hit_stat) begin
			prdata[`OCC_STAT_OPEN] = (state.lock == occ_pkg::occ_open);
			prdata[`OCC_STAT_ARMED] = (state.lock == occ_pkg::occ_armed);
			prdata[`OCC_STAT_HALT] = state.halted;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_first_key;
		wr_ctl && state.lock == occ_pkg::occ_locked && wbyte == `OCC_KEY_FIRST;
	endsequence

	sequence s_second_key;
		wr_ctl && state.lock == occ_pkg::occ_armed && wbyte == `OCC_KEY_SECOND;
	endsequence

	sequence s_config_write;
		wr_ctl && state.lock == occ_pkg::occ_open;
	endsequence

	a_first_key_arms: assert property (
		s_first_key |=> state.lock == occ_pkg::occ_armed && state.ctl == $past(state.ctl)
	) else $error("first key did not arm the lock");

	a_second_key_opens: assert property (
		s_second_key |=> state.lock == occ_pkg::occ_open && state.ctl == $past(state.ctl)
	) else $error("second key did not open the lock");

	a_write_relocks: assert property (
		s_config_write |=> state.lock == occ_pkg::occ_locked && state.ctl == $past(wbyte)
	) else $error("config write not stored or not relocked");

	// next access needs a setup cycle first; three accesses cannot fit in five cycles
	a_full_unlock_path: assert property (
		s_config_write ##[2:5] wr_ctl |=> state.ctl == $past(state.ctl)
	) else $error("write soon after config write changed the register");

	a_locked_write_kept: assert property (
		(wr_ctl && state.lock != occ_pkg::occ_open) |=> state.ctl == $past(state.ctl)
	) else $error("locked write changed the register");

	a_broken_key_relocks: assert property (
		(wr_ctl && state.lock == occ_pkg::occ_armed && wbyte != `OCC_KEY_SECOND)
			|=> state.lock == occ_pkg::occ_locked
	) else $error("broken key sequence left lock open or armed");

	a_osc_enables_follow: assert property (
		(s_config_write ##1 !state.halted) |-> internal_osc_on == $past(wbyte[7])
			&& crystal_osc_on == $past(wbyte[6]) && watchdog_osc_on == $past(wbyte[5])
	) else $error("oscillator enables do not follow the written value");

	a_crystal_pins: assert property (
		crystal_osc_on |-> crystal_pin_a_override && crystal_pin_b_override
	) else $error("crystal enabled but pins not overridden");

	a_detect_and_select: assert property (
		s_config_write |=> system_clock_source_select == $past(wbyte[2:0])
			&& (state.halted || primary_fail_detect_on == $past(wbyte[4]))
			&& (state.halted || watchdog_fail_detect_on == $past(wbyte[3]))
	) else $error("detect or select output does not follow the write");

	a_halt_sticky: assert property (
		(clk_en && all_off) |=> device_halted ##1 device_halted
	) else $error("halt not entered or not held");

	a_read_current: assert property (
		(access && !pwrite && hit_ctl) |-> prdata == {24'h00_0000, state.ctl} && !pslverr
	) else $error("read of control register wrong");

	a_halt_outputs_off: assert property (
		device_halted |-> !internal_osc_on && !crystal_osc_on && !watchdog_osc_on
			&& !primary_fail_detect_on && !watchdog_fail_detect_on
	) else $error("enable still on while halted");

	a_halt_blocks_write: assert property (
		(device_halted && access && pwrite && hit_ctl) |=> state.ctl == $past(state.ctl)
	) else $error("write while halted changed the register");

	a_wrong_first_key: assert property (
		(wr_ctl && state.lock == occ_pkg::occ_locked && wbyte != `OCC_KEY_FIRST)
			|=> state.lock == occ_pkg::occ_locked
	) else $error("wrong first key left the lock armed");

endmodule : occ_control

// file: occ_map.svh
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH

// register indices; byte address is four times the index
`define OCC_CTL_IDX 12'hf86
`define OCC_STAT_IDX 12'hf87

`define OCC_CTL_RESET 8'ha0

// control register fields
`define OCC_BIT_INT 7
`define OCC_BIT_XTL 6
`define OCC_BIT_WDT 5
`define OCC_BIT_PFD 4
`define OCC_BIT_WFD 3
`define OCC_SEL_HI 2
`define OCC_SEL_LO 0

// status register fields
`define OCC_STAT_OPEN 0
`define OCC_STAT_ARMED 1
`define OCC_STAT_HALT 2

// unlock keys
`define OCC_KEY_FIRST 8'he7
`define OCC_KEY_SECOND 8'h18

// clock source select codes
`define OCC_SRC_INT 3'h0
`define OCC_SRC_XTL 3'h1
`define OCC_SRC_WDT 3'h2

`endif

// file: occ_pkg.sv
package occ_pkg;

	// gray along locked -> armed -> open
	typedef enum logic [1:0] {
		occ_locked = 2'b00,
		occ_armed = 2'b01,
		occ_open = 2'b11
	} occ_lock_type;

	typedef struct packed {
		logic [7:0] ctl;
		occ_lock_type lock;
		logic halted;
	} occ_state_type;

endpackage : occ_pkg

// file: occ_osc_model.sv
`timescale 1ns/1ns
module occ_osc_model (
	input wire logic int_on,
	input wire logic xtl_on,
	input wire logic wdt_on,
	input wire logic [2:0] sel,
	output logic clock_alive
);
	// system clock ticks only while the chosen source runs
	always_comb begin
		case (sel)
			3'h0: clock_alive = int_on;
			3'h1: clock_alive = xtl_on;
			3'h2: clock_alive = wdt_on;
			default: clock_alive = 1'b0;
		endcase
	end
endmodule : occ_osc_model

// file: oscillator_control_lock_bench.sv
`timescale 1ns/1ns
`include "occ_map.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("Error %0t: got %h want %h", $time, a, b); end end
module oscillator_control_lock_bench;
	logic pclk = 0;
	logic presetn = 0;
	logic clk_en = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [13:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, er, io, xo, wo, pf, wf, pa, pb, halted, alive;
	logic [2:0] sel;
	int fails = 0;
	int checks = 0;
	localparam logic [13:0] CTL = {`OCC_CTL_IDX, 2'b00};
	localparam logic [13:0] STAT = {`OCC_STAT_IDX, 2'b00};
	initial forever #50 pclk = ~pclk;
	occ_control uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .internal_osc_on(io),
		.crystal_osc_on(xo), .watchdog_osc_on(wo), .primary_fail_detect_on(pf),
		.watchdog_fail_detect_on(wf), .system_clock_source_select(sel),
		.crystal_pin_a_override(pa), .crystal_pin_b_override(pb), .device_halted(halted));
	occ_osc_model osc (.int_on(io), .xtl_on(xo), .wdt_on(wo), .sel(sel), .clock_alive(alive));
	////////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [13:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	// unlock, write, then read back
	task automatic cfg(input logic [7:0] d);
		apb(1, CTL, `OCC_KEY_FIRST);
		apb(1, CTL, `OCC_KEY_SECOND);
		apb(1, CTL, d);
		apb(0, CTL, 8'h00);
	endtask : cfg
	task automatic print_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		fails++;
		print_verdict();
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		apb(0, CTL, 8'h00);
		`CHK(rd, 32'h000000a0)
		`CHK({io, xo, wo, pf, wf, sel, halted}, 9'h140)
		`CHK(er, 1'b0)
		apb(1, CTL, 8'h5f);
		apb(1, CTL, `OCC_KEY_FIRST);
		apb(1, CTL, 8'h55);
		apb(1, CTL, `OCC_KEY_SECOND);
		apb(1, CTL, 8'h5f);
		apb(0, CTL, 8'h00);
		`CHK(rd[7:0], 8'ha0)
		apb(0, STAT, 8'h00);
		`CHK(rd, 32'h00000000)
		// first key only taken once the enable returns
		clk_en <= 0;
		fork
			apb(1, CTL, `OCC_KEY_FIRST);
			begin
				repeat (4) @(posedge pclk);
				`CHK(pready, 1'b0)
				clk_en <= 1;
			end
		join
		apb(0, STAT, 8'h00);
		`CHK(rd, 32'h00000002)
		apb(1, CTL, `OCC_KEY_SECOND);
		apb(0, STAT, 8'h00);
		`CHK(rd, 32'h00000001)
		apb(1, CTL, 8'h59);
		apb(1, CTL, 8'ha0);
		apb(0, CTL, 8'h00);
		`CHK(rd[7:0], 8'h59)
		apb(0, STAT, 8'h00);
		`CHK(rd, 32'h00000000)
		`CHK({io, xo, wo, pf, wf, sel}, 8'h59)
		`CHK({pa, pb, alive}, 3'b111)
		apb(1, 14'h0100, 8'h00);
		`CHK(er, 1'b1)
		cfg(8'h02);
		apb(0, CTL, 8'h00);
		`CHK({halted, io, xo, wo, pf, wf}, 6'h20)
		`CHK(alive, 1'b0)
		cfg(8'ha0);
		`CHK(rd[7:0], 8'h02)
		// only a reset brings a halted block back
		@(posedge pclk);
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		apb(0, CTL, 8'h00);
		`CHK(rd[7:0], 8'ha0)
		`CHK({halted, io, wo}, 3'b011)
		print_verdict();
	end
endmodule : oscillator_control_lock_bench
